// ===== stp_pkg.sv
package stp_pkg;

  // ----------------------------------------------------------------
  // register sizes
  // ----------------------------------------------------------------
  localparam int STP_IR_W = 3;          // instruction register width
  localparam int STP_ID_W = 32;         // identification register width
  localparam int STP_BSR_W = 109;       // boundary chain length
  localparam int STP_OE_CELL = 108;     // output-control cell position
  localparam int STP_RESET_EDGES = 5;   // tms-high edges that reach reset

  // ----------------------------------------------------------------
  // instruction codes
  // ----------------------------------------------------------------
  localparam logic [2:0] STP_INS_EXTEST = 3'h0;   // external test
  localparam logic [2:0] STP_INS_IDCODE = 3'h1;   // identification
  localparam logic [2:0] STP_INS_SAMPZ = 3'h2;    // sample, outputs off
  localparam logic [2:0] STP_INS_SAMPLE = 3'h4;   // sample / preload
  localparam logic [2:0] STP_INS_BYPASS = 3'h7;   // bypass
  localparam logic [2:0] STP_IR_CAPTURE = 3'h1;   // capture-ir pattern, low bits 01

  // ----------------------------------------------------------------
  // identification word fields
  // ----------------------------------------------------------------
  localparam int STP_REV_LSB = 29;      // revision field 31:29
  localparam int STP_PART_LSB = 12;     // part-type field 28:12
  localparam int STP_MFR_LSB = 1;       // manufacturer field 11:1
  localparam logic STP_ID_PRESENT = 1'b1;  // bit 0 always one

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
    ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
    ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } stp_state_t;

endpackage : stp_pkg

// ===== stp_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser for pin inputs
module stp_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;  // first stage, read only by second

  // ----------------------------------------------------------------
  // two stages
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : stp_sync

`default_nettype wire

// ===== stp_tap.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// (R1) state advances on tck rise per tms
// (R2) 3-bit instruction; 000 external test captures ring
// (R3) 001 selects fixed 32-bit identification word
// (R4) 010 samples pins, outputs forced off
// (R5) 100 samples into 109-cell chain
// (R6) 111 selects single-bit bypass
// (R7) controller never loads 011, 101, 110
// (R8) id revision 31:29, part 28:12 fixed
// (R9) id bits 11:1 fixed manufacturer code
// (R10) id bit 0 always one
// (R11) five tms-high edges reset, load identification
// (R12) tdi sampled on rise, tdo on fall
// (R13) capture-ir loads low bits 01
// (R14) cell 108 gates outputs under external test
// (R15) full sixteen-state controller
module stp_tap #(
  parameter logic [2:0] REV_CODE = 3'h5,        // arbitrary value
  parameter logic [16:0] PART_CODE = 17'h0abcd, // arbitrary value
  parameter logic [10:0] MFR_CODE = 11'h2aa     // arbitrary value
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // test pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // memory ring
  input wire logic [stp_pkg::STP_BSR_W-1:0] ring_in,
  output logic [stp_pkg::STP_BSR_W-1:0] ring_out,
  output logic extest_active,
  output logic q_out_en
);

  // ----------------------------------------------------------------
  // pin synchronisation and tck edges
  // ----------------------------------------------------------------
  logic [2:0] pins_s;      // synchronised tck, tms, tdi
  logic tck_s;             // synced tck
  logic tms_s;             // synced tms
  logic tdi_s;             // synced tdi
  logic tck_d_reg;         // previous synced tck
  wire tck_rise;           // rising tck seen
  wire tck_fall;           // falling tck seen

  stp_sync #(.WIDTH(3)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d({tck, tms, tdi}),
    .q(pins_s)
  );

  assign tck_s = pins_s[2];
  assign tms_s = pins_s[1];
  assign tdi_s = pins_s[0];
  assign tck_rise = tck_s & ~tck_d_reg;
  assign tck_fall = ~tck_s & tck_d_reg;

  // edge detect history
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tck_d_reg <= 1'b0;
    end else begin
      tck_d_reg <= tck_s;
    end
  end

  // ----------------------------------------------------------------
  // controller state machine
  // ----------------------------------------------------------------
  stp_pkg::stp_state_t state_reg;
  stp_pkg::stp_state_t state_next;

  // next state from tms [R15]
  always_comb begin
    case (state_reg)
      stp_pkg::ST_RESET: state_next = tms_s ? stp_pkg::ST_RESET : stp_pkg::ST_IDLE;
      stp_pkg::ST_IDLE: state_next = tms_s ? stp_pkg::ST_SEL_DR : stp_pkg::ST_IDLE;
      stp_pkg::ST_SEL_DR: state_next = tms_s ? stp_pkg::ST_SEL_IR : stp_pkg::ST_CAP_DR;
      stp_pkg::ST_CAP_DR: state_next = tms_s ? stp_pkg::ST_EXIT1_DR : stp_pkg::ST_SHIFT_DR;
      stp_pkg::ST_SHIFT_DR: state_next = tms_s ? stp_pkg::ST_EXIT1_DR : stp_pkg::ST_SHIFT_DR;
      stp_pkg::ST_EXIT1_DR: state_next = tms_s ? stp_pkg::ST_UPD_DR : stp_pkg::ST_PAUSE_DR;
      stp_pkg::ST_PAUSE_DR: state_next = tms_s ? stp_pkg::ST_EXIT2_DR : stp_pkg::ST_PAUSE_DR;
      stp_pkg::ST_EXIT2_DR: state_next = tms_s ? stp_pkg::ST_UPD_DR : stp_pkg::ST_SHIFT_DR;
      stp_pkg::ST_UPD_DR: state_next = tms_s ? stp_pkg::ST_SEL_DR : stp_pkg::ST_IDLE;
      stp_pkg::ST_SEL_IR: state_next = tms_s ? stp_pkg::ST_RESET : stp_pkg::ST_CAP_IR;
      stp_pkg::ST_CAP_IR: state_next = tms_s ? stp_pkg::ST_EXIT1_IR : stp_pkg::ST_SHIFT_IR;
      stp_pkg::ST_SHIFT_IR: state_next = tms_s ? stp_pkg::ST_EXIT1_IR : stp_pkg::ST_SHIFT_IR;
      stp_pkg::ST_EXIT1_IR: state_next = tms_s ? stp_pkg::ST_UPD_IR : stp_pkg::ST_PAUSE_IR;
      stp_pkg::ST_PAUSE_IR: state_next = tms_s ? stp_pkg::ST_EXIT2_IR : stp_pkg::ST_PAUSE_IR;
      stp_pkg::ST_EXIT2_IR: state_next = tms_s ? stp_pkg::ST_UPD_IR : stp_pkg::ST_SHIFT_IR;
      stp_pkg::ST_UPD_IR: state_next = tms_s ? stp_pkg::ST_SEL_DR : stp_pkg::ST_IDLE;
      default: state_next = stp_pkg::ST_RESET;
    endcase
  end

  // advance only on tck rise [R1]
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= stp_pkg::ST_RESET;
    end else if (tck_rise) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [2:0] ir_reg;      // active instruction
  logic [2:0] ir_sh_reg;   // instruction shift stage
  logic [stp_pkg::STP_ID_W-1:0] dr_id_reg;    // id shift stage
  logic [stp_pkg::STP_BSR_W-1:0] bsr_reg;     // boundary shift stage
  logic bypass_reg;        // bypass cell
  logic oe_cell_reg;       // latched output-control cell
  // entering or staying in reset at this tck rise, so the instruction is ready on arrival
  wire to_reset = (state_next == stp_pkg::ST_RESET);
  wire cap_dr = (state_reg == stp_pkg::ST_CAP_DR);
  wire sh_dr = (state_reg == stp_pkg::ST_SHIFT_DR);
  wire upd_dr = (state_reg == stp_pkg::ST_UPD_DR);
  wire cap_ir = (state_reg == stp_pkg::ST_CAP_IR);
  wire sh_ir = (state_reg == stp_pkg::ST_SHIFT_IR);
  wire upd_ir = (state_reg == stp_pkg::ST_UPD_IR);
  // chain serves external test and both sample codes [R2] [R4] [R5]
  wire sel_bsr = (ir_reg == stp_pkg::STP_INS_EXTEST) | (ir_reg == stp_pkg::STP_INS_SAMPZ)
                 | (ir_reg == stp_pkg::STP_INS_SAMPLE);
  wire sel_id = (ir_reg == stp_pkg::STP_INS_IDCODE);
  // fixed identification word [R8] [R9] [R10]
  wire [stp_pkg::STP_ID_W-1:0] id_word = {REV_CODE, PART_CODE, MFR_CODE,
                                         stp_pkg::STP_ID_PRESENT};
  // undefined codes (never loaded) fall to bypass [R7]
  wire dr_out = sel_bsr ? bsr_reg[0] : (sel_id ? dr_id_reg[0] : bypass_reg); // [R3] [R6]
  wire ser_out = sh_ir ? ir_sh_reg[0] : dr_out;

  // ----------------------------------------------------------------
  // instruction path
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ir_reg <= stp_pkg::STP_INS_IDCODE;
      ir_sh_reg <= stp_pkg::STP_IR_CAPTURE;
    end else if (tck_rise) begin
      if (to_reset) begin
        ir_reg <= stp_pkg::STP_INS_IDCODE;          // [R11]
      end else if (cap_ir) begin
        ir_sh_reg <= stp_pkg::STP_IR_CAPTURE;       // [R13]
      end else if (sh_ir) begin
        ir_sh_reg <= {tdi_s, ir_sh_reg[2:1]};       // [R2] [R12]
      end else if (upd_ir) begin
        ir_reg <= ir_sh_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // data paths: capture, shift, update
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dr_id_reg <= '0;
      bsr_reg <= '0;
      bypass_reg <= 1'b0;
      oe_cell_reg <= 1'b0;
    end else if (tck_rise) begin
      if (to_reset) begin
        oe_cell_reg <= 1'b0;                        // [R14]
      end else if (cap_dr) begin
        dr_id_reg <= id_word;                       // [R3]
        bsr_reg <= ring_in;                         // [R2] [R4] [R5]
        bypass_reg <= 1'b0;                         // [R6]
      end else if (sh_dr) begin
        if (sel_bsr) begin
          bsr_reg <= {tdi_s, bsr_reg[stp_pkg::STP_BSR_W-1:1]}; // [R12]
        end else if (sel_id) begin
          dr_id_reg <= {tdi_s, dr_id_reg[stp_pkg::STP_ID_W-1:1]};
        end else begin
          bypass_reg <= tdi_s;                      // [R6]
        end
      end else if (upd_dr && sel_bsr) begin
        oe_cell_reg <= bsr_reg[stp_pkg::STP_OE_CELL]; // [R14]
      end
    end
  end

  // preload update register for the ring drivers; its cell 108 mirrors the latch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ring_out <= '0;
    end else if (tck_rise && upd_dr && sel_bsr) begin
      ring_out <= bsr_reg;
    end else if (tck_rise && to_reset) begin
      ring_out[stp_pkg::STP_OE_CELL] <= 1'b0;       // [R14]
    end
  end

  // ----------------------------------------------------------------
  // serial output on tck fall, and memory output control
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
      extest_active <= 1'b0;
      q_out_en <= 1'b1;
    end else begin
      if (tck_fall) begin
        tdo <= ser_out;                             // [R12]
        tdo_oe <= sh_ir | sh_dr;
      end
      extest_active <= (ir_reg == stp_pkg::STP_INS_EXTEST);
      if (ir_reg == stp_pkg::STP_INS_SAMPZ) begin
        q_out_en <= 1'b0;                           // [R4]
      end else if (ir_reg == stp_pkg::STP_INS_EXTEST) begin
        q_out_en <= oe_cell_reg;                    // [R14]
      end else begin
        q_out_en <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [2:0] tms_hi_cnt;  // consecutive tms-high tck rises
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tms_hi_cnt <= 3'h0;
    end else if (tck_rise) begin
      tms_hi_cnt <= !tms_s ? 3'h0 : (tms_hi_cnt == 3'h5 ? 3'h5 : tms_hi_cnt + 3'h1);
    end
  end

  tms_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R11]
    tms_hi_cnt == 3'h5 |-> state_reg == stp_pkg::ST_RESET && ir_reg == stp_pkg::STP_INS_IDCODE)
    else $error("five tms-high edges did not reset");
  state_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R1]
    !tck_rise |=> $stable(state_reg)) else $error("state moved without tck rise");
  ir_capture_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R13]
    tck_rise && cap_ir |=> ir_sh_reg[1:0] == 2'b01) else $error("capture-ir pattern wrong");
  id_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R3]
    tck_rise && cap_dr |=> dr_id_reg == id_word) else $error("id word not captured");
  id_bit0_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R10]
    tck_rise && cap_dr |=> dr_id_reg[0] == 1'b1) else $error("id presence bit low");
  sampz_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R4]
    ir_reg == stp_pkg::STP_INS_SAMPZ ##1 ir_reg == stp_pkg::STP_INS_SAMPZ |-> !q_out_en)
    else $error("outputs not forced off");
  bypass_cap_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R6]
    tck_rise && cap_dr |=> !bypass_reg) else $error("bypass not cleared on capture");
  tdo_fall_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R12]
    !tck_fall |=> $stable(tdo)) else $error("tdo changed away from tck fall");
  bsr_cap_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R5]
    tck_rise && cap_dr |=> bsr_reg == $past(ring_in)) else $error("chain not captured");

endmodule : stp_tap

`default_nettype wire

// ===== stp_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// board test controller model
// ----------------------------------------------------------------
module stp_ctl_model (
  // sampling clock for pin timing
  input wire logic clk_sys,
  // test pins
  input wire logic tdo,
  input wire logic tdo_oe,
  output var logic tck,
  output var logic tms,
  output var logic tdi
);
  logic last_bit; // level seen on the serial out line
  logic oe_seen;  // serial out driven at the last sample

  // pins idle: clock low, mode high
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    last_bit = 1'b0;
    oe_seen = 1'b0;
  end

  // one test clock period of 80 ns, mode and data set while clock low
  task automatic step(input logic m, input logic d);
    tms = m;
    tdi = d;
    repeat (5) @(negedge clk_sys);
    tck = 1'b1;
    repeat (5) @(negedge clk_sys);
    // released line shows the inverse of its last level
    last_bit = tdo_oe ? tdo : ~last_bit;
    oe_seen = tdo_oe;
    tck = 1'b0;
  endtask : step

  // five mode-high clocks, then park in idle
  task automatic tap_reset();
    repeat (5) step(1'b1, ~tdi);
    step(1'b0, ~tdi);
  endtask : tap_reset

  // full scan from idle back to idle, lsb first; data toggles outside shift
  // only documented instruction codes are ever handed in here
  task automatic scan(input logic is_ir, input int n, input logic [108:0] din,
                      output logic [108:0] dout, output logic oe_ok);
    int i;
    dout = '0;
    oe_ok = 1'b1;
    step(1'b1, ~tdi);
    if (is_ir) begin
      step(1'b1, ~tdi);
    end
    step(1'b0, ~tdi);
    step(1'b0, ~tdi);
    for (i = 0; i < n; i++) begin
      step(i == n - 1, din[i]);
      dout[i] = last_bit;
      oe_ok = oe_ok & oe_seen;
    end
    step(1'b1, ~tdi);
    step(1'b0, ~tdi);
  endtask : scan
endmodule : stp_ctl_model

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// top level bench
// ----------------------------------------------------------------
module testbench;
  localparam logic [2:0] REV = 3'h3;      // arbitrary value
  localparam logic [16:0] PART = 17'h01234; // arbitrary value
  localparam logic [10:0] MFR = 11'h155;  // arbitrary value
  localparam logic [31:0] ID_EXP = {REV, PART, MFR, 1'b1};
  localparam logic [108:0] PAT = {{4{27'h5a3c6e1}}, 1'b1};
  localparam logic [108:0] PRE1 = {1'b1, {9{12'h9c3}}};
  localparam logic [108:0] PRE2 = {1'b0, PRE1[107:0]};

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic [108:0] ring_in = PAT; // pin states seen by capture
  logic [108:0] ring_out;
  logic extest_active;
  logic q_out_en;
  logic [108:0] d;
  logic ok;
  int n_mismatch = 0;
  int n_tests = 0;

  // 125 mhz system clock
  initial forever #4 clk_sys = ~clk_sys;

  stp_tap #(.REV_CODE(REV), .PART_CODE(PART), .MFR_CODE(MFR)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .ring_in(ring_in), .ring_out(ring_out),
    .extest_active(extest_active), .q_out_en(q_out_en)
  );

  stp_ctl_model ctl (
    .clk_sys(clk_sys), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [108:0] seen, input logic [108:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check

  // load an instruction and look at the captured low bits
  task automatic load(input logic [2:0] code);
    ctl.scan(1'b1, 3, {106'h0, code}, d, ok);
    check(d[1:0], 2'b01);
    check(ok, 1'b1);
  endtask : load

  // read the identification word
  task automatic read_id();
    ctl.scan(1'b0, 32, '0, d, ok);
    check(d[31:0], ID_EXP);
    check(ok, 1'b1);
  endtask : read_id

  // hang guard
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_mismatch++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    check(q_out_en, 1'b1);
    check(ring_out, '0);
    check(extest_active, 1'b0);
    check(tdo_oe, 1'b0);
    ctl.step(1'b0, 1'b0);
    read_id();
    // bypass delays the stream by one bit, captured zero first
    load(stp_pkg::STP_INS_BYPASS);
    ctl.scan(1'b0, 4, 109'hb, d, ok);
    check(d[3:0], 4'h6);
    // sample and preload
    load(stp_pkg::STP_INS_SAMPLE);
    ctl.scan(1'b0, 109, PRE1, d, ok);
    check(d, PAT);
    check(ring_out, PRE1);
    check(q_out_en, 1'b1);
    check(extest_active, 1'b0);
    // external test, output control cell gates the drivers
    load(stp_pkg::STP_INS_EXTEST);
    check(extest_active, 1'b1);
    check(q_out_en, 1'b1);
    ctl.scan(1'b0, 109, PRE2, d, ok);
    check(d, PAT);
    check(ring_out, PRE2);
    check(q_out_en, 1'b0);
    // sample with outputs off, cell high does not matter
    load(stp_pkg::STP_INS_SAMPZ);
    ctl.scan(1'b0, 109, PRE1, d, ok);
    check(d, PAT);
    check(q_out_en, 1'b0);
    check(extest_active, 1'b0);
    // mode-high reset restores identification and clears the cell
    ctl.tap_reset();
    check(q_out_en, 1'b1);
    check(ring_out[stp_pkg::STP_OE_CELL], 1'b0);
    read_id();
    // data shift interrupted by pause and exit2 resumes at the next bit
    ctl.step(1'b1, 1'b0);
    ctl.step(1'b0, 1'b0);
    ctl.step(1'b0, 1'b0);
    ctl.step(1'b0, 1'b0);
    check(ctl.last_bit, ID_EXP[0]);
    ctl.step(1'b1, 1'b0);
    check(ctl.last_bit, ID_EXP[1]);
    ctl.step(1'b0, 1'b0);
    ctl.step(1'b1, 1'b0);
    ctl.step(1'b0, 1'b0);
    ctl.step(1'b1, 1'b0);
    check(ctl.last_bit, ID_EXP[2]);
    check(ctl.oe_seen, 1'b1);
    ctl.step(1'b1, 1'b0);
    ctl.step(1'b0, 1'b0);
    // cell cleared by reset keeps the outputs off under external test
    load(stp_pkg::STP_INS_EXTEST);
    check(extest_active, 1'b1);
    check(q_out_en, 1'b0);
    stop_test();
  end
endmodule : testbench

`default_nettype wire
